// [core/hpsel_top.sv]
`timescale 1ns/10ps
module hpsel_top (
	// clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    arst_n,
	input  wire logic                    clk_en,
	// shared host pins
	input  wire logic                    host_clk_pin,
	input  wire logic                    data2_or_port_strap_pin_i,
	output logic                         data2_or_port_strap_pin_o,
	output logic                         data2_or_port_strap_pin_oe,
	input  hpsel_pkg::hpsel_pins_s       pins_i,
	output hpsel_pkg::hpsel_pins_s       pins_o,
	output hpsel_pkg::hpsel_pins_oe_s    pins_oe,
	// sideband pins
	input  wire logic                    wake_or_gpio_pin_i,
	output logic                         wake_or_gpio_pin_o,
	output logic                         wake_or_gpio_pin_oe,
	input  wire logic                    irq_mirror_or_gpio_pin_i,
	output logic                         irq_mirror_or_gpio_pin_o,
	output logic                         irq_mirror_or_gpio_pin_oe,
	// core configuration
	input  wire logic                    power_save_en,
	input  wire logic                    irq_mirror_en,
	input  wire logic                    wake_gpio_out,
	input  wire logic                    wake_gpio_oe,
	input  wire logic                    mirror_gpio_out,
	input  wire logic                    mirror_gpio_oe,
	input  wire logic                    sleep_request,
	input  wire logic                    host_irq_request,
	// core side protocol engines
	input  hpsel_pkg::hpsel_spi_out_s    spi_out,
	input  hpsel_pkg::hpsel_sdio_out_s   sdio_out,
	output hpsel_pkg::hpsel_spi_in_s     spi_in,
	output hpsel_pkg::hpsel_sdio_in_s    sdio_in,
	// status
	output hpsel_pkg::hpsel_mode_e       port_mode,
	output logic                         mode_valid,
	output logic                         host_wake_input,
	output logic                         wake_gpio_in,
	output logic                         mirror_gpio_in,
	output logic                         sleep_grant
);
	import hpsel_pkg::*;

	// ****************************************
	// input synchronisers
	// ****************************************
	localparam int SYNC_W = 8;
	// start at idle levels (clock and mirror pin low, the rest pulled up, deselected) so release gives no false select
	localparam logic [SYNC_W-1:0] SYNC_IDLE = 8'h7e;
	logic [SYNC_W-1:0] raw_vec;
	logic [SYNC_W-1:0] syn_vec;
	logic [SYNC_W-1:0] syn_rise;
	logic [SYNC_W-1:0] syn_fall;

	assign raw_vec = {host_clk_pin, pins_i.cmd, pins_i.dat0, pins_i.dat1, pins_i.dat3,
		data2_or_port_strap_pin_i, wake_or_gpio_pin_i, irq_mirror_or_gpio_pin_i};

	hpsel_sync #(
		.WIDTH    (SYNC_W),
		.IDLE_LVL (SYNC_IDLE)
	) u_sync (
		.clk_sys  (clk_sys),
		.arst_n   (arst_n),
		.clk_en   (clk_en),
		.async_in (raw_vec),
		.sync_out (syn_vec),
		.rise     (syn_rise),
		.fall     (syn_fall)
	);

	logic s_clk;
	logic s_cmd;
	logic s_d0;
	logic s_d1;
	logic s_d3;
	logic s_d2;
	logic s_wake;
	logic s_mirror;
	assign {s_clk, s_cmd, s_d0, s_d1, s_d3, s_d2, s_wake, s_mirror} = syn_vec;

	// ****************************************
	// strap capture
	// ****************************************
	// the strap is taken directly from the pin in the first enabled
	// cycle after reset release; the host holds it steady around release
	logic        captured_reg;
	hpsel_mode_e mode_reg;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			captured_reg <= 1'b0;
			mode_reg     <= HPSEL_SPI;
		end else if (clk_en && !captured_reg) begin
			captured_reg <= 1'b1;
			mode_reg     <= (data2_or_port_strap_pin_i == STRAP_SDIO_LEVEL) ? HPSEL_SDIO
				: HPSEL_SPI;
		end
	end

	function automatic logic is_sdio(input hpsel_mode_e m, input logic v);
		return v && (m == HPSEL_SDIO);
	endfunction

	function automatic logic is_spi(input hpsel_mode_e m, input logic v);
		return v && (m == HPSEL_SPI);
	endfunction

	logic sdio_sel;
	logic spi_sel;
	assign sdio_sel = is_sdio(mode_reg, captured_reg);
	assign spi_sel  = is_spi(mode_reg, captured_reg);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			port_mode  <= HPSEL_SPI;
			mode_valid <= 1'b0;
		end else if (clk_en) begin
			port_mode  <= mode_reg;
			mode_valid <= captured_reg;
		end
	end

	// ****************************************
	// inbound routing
	// ****************************************
	logic spi_active;
	assign spi_active = spi_sel && (s_d3 == SELECT_ACTIVE);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			spi_in  <= '0;
			sdio_in <= '0;
		end else if (clk_en) begin
			spi_in.sclk   <= spi_sel & s_clk;
			spi_in.sclk_rise <= spi_active & syn_rise[SYNC_W-1];
			spi_in.sclk_fall <= spi_active & syn_fall[SYNC_W-1];
			spi_in.mosi   <= spi_sel & s_cmd;
			spi_in.select <= spi_active;
			sdio_in.clk      <= sdio_sel & s_clk;
			sdio_in.clk_rise <= sdio_sel & syn_rise[SYNC_W-1];
			sdio_in.clk_fall <= sdio_sel & syn_fall[SYNC_W-1];
			sdio_in.cmd      <= sdio_sel & s_cmd;
			sdio_in.dat      <= sdio_sel ? {s_d3, s_d2, s_d1, s_d0} : 4'h0;
		end
	end

	// ****************************************
	// outbound routing
	// ****************************************
	// outbound pin mapping
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pins_o                     <= '0;
			pins_oe                    <= '0;
			data2_or_port_strap_pin_o  <= 1'b0;
			data2_or_port_strap_pin_oe <= 1'b0;
		end else if (clk_en) begin
			pins_o  <= '0;
			pins_oe <= '0;
			data2_or_port_strap_pin_o  <= 1'b0;
			data2_or_port_strap_pin_oe <= 1'b0;
			if (sdio_sel) begin
				pins_o.cmd   <= sdio_out.cmd;
				pins_oe.cmd  <= sdio_out.cmd_oe;
				pins_o.dat0  <= sdio_out.dat[0];
				pins_oe.dat0 <= sdio_out.dat_oe[0];
				pins_o.dat1  <= sdio_out.dat[1];
				pins_oe.dat1 <= sdio_out.dat_oe[1];
				pins_o.dat3  <= sdio_out.dat[3];
				pins_oe.dat3 <= sdio_out.dat_oe[3];
				data2_or_port_strap_pin_o  <= sdio_out.dat[2];
				data2_or_port_strap_pin_oe <= sdio_out.dat_oe[2];
			end else if (spi_sel) begin
				pins_o.dat0  <= spi_out.miso;
				pins_oe.dat0 <= spi_out.miso_oe & spi_active;
				pins_o.dat1  <= host_irq_request;
				pins_oe.dat1 <= 1'b1;
			end
		end
	end

	// ****************************************
	// sideband pins
	// ****************************************
	// wake pin as gpio
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wake_or_gpio_pin_o  <= 1'b0;
			wake_or_gpio_pin_oe <= 1'b0;
			host_wake_input     <= 1'b0;
			wake_gpio_in        <= 1'b0;
		end else if (clk_en) begin
			wake_or_gpio_pin_o  <= !power_save_en & wake_gpio_out;
			wake_or_gpio_pin_oe <= !power_save_en & wake_gpio_oe;
			host_wake_input     <= power_save_en & s_wake;
			wake_gpio_in        <= !power_save_en & s_wake;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sleep_grant <= 1'b0;
		end else if (clk_en) begin
			sleep_grant <= sleep_request && (s_wake == WAKE_ALLOW_SLEEP);
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			irq_mirror_or_gpio_pin_o  <= 1'b0;
			irq_mirror_or_gpio_pin_oe <= 1'b0;
			mirror_gpio_in            <= 1'b0;
		end else if (clk_en) begin
			irq_mirror_or_gpio_pin_o  <= irq_mirror_en ? host_irq_request : mirror_gpio_out;
			irq_mirror_or_gpio_pin_oe <= irq_mirror_en | mirror_gpio_oe;
			mirror_gpio_in            <= !irq_mirror_en & s_mirror;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	// mode stable once valid
	AST_MODE_FIXED: assert property (@(posedge clk_sys) disable iff (!arst_n)
		captured_reg && $past(captured_reg) |-> $stable(mode_reg))
		else $error("mode changed after capture");

	AST_CAPTURE: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!captured_reg && clk_en |=> captured_reg)
		else $error("strap not captured");

	AST_STRAP_MAP: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!captured_reg && clk_en |=> (mode_reg == HPSEL_SDIO) == $past(data2_or_port_strap_pin_i))
		else $error("wrong personality for strap");

	// irq driven on data1 in spi
	AST_SPI_IRQ: assert property (@(posedge clk_sys) disable iff (!arst_n)
		spi_sel && clk_en |=> pins_oe.dat1 && pins_o.dat1 == $past(host_irq_request))
		else $error("data1 not carrying irq");

	// sdio drives dat2 only in sdio
	AST_DAT2_OE: assert property (@(posedge clk_sys) disable iff (!arst_n)
		data2_or_port_strap_pin_oe |-> sdio_sel)
		else $error("dat2 driven outside sdio");

	// no spi edges while deselected, dat0 only driven by sdio then
	AST_SPI_GATE: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && !spi_active |=> !spi_in.sclk_rise && !spi_in.sclk_fall
			&& (!pins_oe.dat0 || $past(sdio_sel)))
		else $error("spi active while deselected");

	// no sleep grant with wake high
	AST_SLEEP: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && s_wake |=> !sleep_grant)
		else $error("sleep granted while wake high");

	// wake pin gpio drive off in power save
	AST_WAKE_GPIO: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && power_save_en |=> !wake_or_gpio_pin_oe)
		else $error("wake pin driven in power save");

	AST_MIRROR: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && irq_mirror_en |=> irq_mirror_or_gpio_pin_oe
			&& irq_mirror_or_gpio_pin_o == $past(host_irq_request))
		else $error("mirror pin wrong");

	COV_SPI: cover property (@(posedge clk_sys) disable iff (!arst_n)
		spi_in.sclk_rise);
	COV_SDIO: cover property (@(posedge clk_sys) disable iff (!arst_n)
		sdio_sel && sdio_in.clk_rise);
	COV_SLEEP: cover property (@(posedge clk_sys) disable iff (!arst_n)
		sleep_grant);
	COV_MIRROR: cover property (@(posedge clk_sys) disable iff (!arst_n)
		irq_mirror_en && irq_mirror_or_gpio_pin_o);

endmodule : hpsel_top

// [common/hpsel_pkg.sv]
package hpsel_pkg;

	// ****************************************
	// personalities
	// ****************************************
	typedef enum logic {
		HPSEL_SPI,
		HPSEL_SDIO
	} hpsel_mode_e;

	// strap level that selects each personality
	localparam logic STRAP_SDIO_LEVEL = 1'b1;

	// chip select active level
	localparam logic SELECT_ACTIVE = 1'b0;

	// wake pin level that permits low-power states
	localparam logic WAKE_ALLOW_SLEEP = 1'b0;

	// ****************************************
	// host clock limits
	// ****************************************
	localparam int SDIO_DS_MAX_MHZ = 26;
	localparam int SDIO_HS_MAX_MHZ = 52;
	localparam int SPI_MAX_MHZ     = 52;

	// ****************************************
	// pin groups
	// ****************************************
	typedef struct packed {
		logic cmd;
		logic dat0;
		logic dat1;
		logic dat3;
	} hpsel_pins_s;

	typedef struct packed {
		logic cmd;
		logic dat0;
		logic dat1;
		logic dat3;
	} hpsel_pins_oe_s;

	// core side, spi personality
	typedef struct packed {
		logic miso;
		logic miso_oe;
	} hpsel_spi_out_s;

	typedef struct packed {
		logic sclk;
		logic sclk_rise;
		logic sclk_fall;
		logic mosi;
		logic select;
	} hpsel_spi_in_s;

	// core side, sdio personality
	typedef struct packed {
		logic cmd;
		logic cmd_oe;
		logic [3:0] dat;
		logic [3:0] dat_oe;
	} hpsel_sdio_out_s;

	typedef struct packed {
		logic clk;
		logic clk_rise;
		logic clk_fall;
		logic cmd;
		logic [3:0] dat;
	} hpsel_sdio_in_s;

endpackage : hpsel_pkg

// [core/hpsel_sync.sv]
`timescale 1ns/10ps
module hpsel_sync #(
	parameter int               WIDTH    = 1,
	parameter logic [WIDTH-1:0] IDLE_LVL = '0
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             arst_n,
	input  wire logic             clk_en,
	// data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);

	// ****************************************
	// three stage synchroniser
	// ****************************************
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] level_reg;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s1_reg <= IDLE_LVL;
			s2_reg <= IDLE_LVL;
			s3_reg <= IDLE_LVL;
		end else if (clk_en) begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// a change counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			always_ff @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n) begin
					level_reg[gi] <= IDLE_LVL[gi];
					rise[gi]      <= 1'b0;
					fall[gi]      <= 1'b0;
				end else if (clk_en) begin
					rise[gi] <= 1'b0;
					fall[gi] <= 1'b0;
					if (s2_reg[gi] == s3_reg[gi] && s2_reg[gi] != level_reg[gi]) begin
						level_reg[gi] <= s2_reg[gi];
						rise[gi]      <= s2_reg[gi];
						fall[gi]      <= ~s2_reg[gi];
					end
				end
			end
		end
	endgenerate

	assign sync_out = level_reg;

endmodule : hpsel_sync

// [verification/hpsel_host_model.sv]
`timescale 1ns/10ps
module hpsel_host_model (
	// clock
	input  wire logic clk_sys,
	// bench request
	input  wire logic wake_req,
	// host pins
	output logic      link_clk,
	output logic      mosi,
	output logic      sel_low,
	output logic      wake_pin
);
	initial begin
		link_clk = 1'b0;
		mosi     = 1'b1;
		sel_low  = 1'b1;
	end

	always @(posedge clk_sys)
		wake_pin <= wake_req;

	// byte frame
	// clock idles low between frames, data line flips once released
	task automatic frame(input logic [7:0] d, input logic sel);
		@(posedge clk_sys);
		sel_low <= ~sel;
		for (int i = 7; i >= 0; i--) begin
			mosi <= d[i];
			repeat (4) @(posedge clk_sys);
			link_clk <= 1'b1;
			repeat (4) @(posedge clk_sys);
			link_clk <= 1'b0;
		end
		repeat (4) @(posedge clk_sys);
		sel_low <= 1'b1;
		mosi    <= ~d[0];
		repeat (8) @(posedge clk_sys);
		#1;
	endtask : frame
endmodule : hpsel_host_model

// [verification/tb.sv]
`timescale 1ns/10ps
module tb;
	import hpsel_pkg::*;
	logic clk_sys = 0, arst_n = 0, strap = 0, wake_req = 0;
	logic ps = 0, mir = 0, goe = 0, gout = 0, slp = 0, irq = 0;
	logic lclk, mosi, sel_low, wpin, d2_o, d2_oe, wo, woe, mo, moe;
	logic mode_valid, sleep_grant, hwi, wgi, mgi, cen = 1;
	hpsel_pins_s pins_i, pins_o;
	hpsel_pins_oe_s pins_oe;
	hpsel_spi_out_s spi_out = '0;
	hpsel_sdio_out_s sdio_out = '0;
	hpsel_spi_in_s spi_in;
	hpsel_sdio_in_s sdio_in;
	hpsel_mode_e port_mode;
	int bad_count = 0, checks = 0, rise_cnt = 0, fall_cnt = 0;
	logic [7:0] data_sh, miso_sh;
	// {ps,mir,wake,slp,irq,goe,gout} then {grant,mo,moe,woe}
	logic [10:0] rows [6] = '{11'b0001011_1111, 11'b1001110_1010, 11'b0111100_0110,
		11'b1110011_0010, 11'b0100110_0111, 11'b0011001_0000};

	initial forever #5 clk_sys = ~clk_sys;

	// wire levels: pull-ups on device pins, host drives cmd and dat3
	assign pins_i = {pins_oe.cmd ? pins_o.cmd : mosi, pins_oe.dat0 ? pins_o.dat0 : 1'b1,
		pins_oe.dat1 ? pins_o.dat1 : 1'b1, pins_oe.dat3 ? pins_o.dat3 : sel_low};

	hpsel_host_model host_u (.clk_sys, .wake_req, .link_clk(lclk), .mosi, .sel_low,
		.wake_pin(wpin));

	hpsel_top dut_u (.clk_sys, .arst_n, .clk_en(cen), .host_clk_pin(lclk),
		.data2_or_port_strap_pin_i(d2_oe ? d2_o : strap), .data2_or_port_strap_pin_o(d2_o),
		.data2_or_port_strap_pin_oe(d2_oe), .pins_i, .pins_o, .pins_oe,
		.wake_or_gpio_pin_i(wpin), .wake_or_gpio_pin_o(wo), .wake_or_gpio_pin_oe(woe),
		.irq_mirror_or_gpio_pin_i(moe ? mo : wpin), .irq_mirror_or_gpio_pin_o(mo),
		.irq_mirror_or_gpio_pin_oe(moe), .power_save_en(ps), .irq_mirror_en(mir),
		.wake_gpio_out(gout), .wake_gpio_oe(goe), .mirror_gpio_out(gout),
		.mirror_gpio_oe(goe), .sleep_request(slp), .host_irq_request(irq), .spi_out,
		.sdio_out, .spi_in, .sdio_in, .port_mode, .mode_valid, .host_wake_input(hwi),
		.wake_gpio_in(wgi), .mirror_gpio_in(mgi), .sleep_grant);

	// seen edges and the data bit at each
	// host takes miso or dat0 at the rising edge (high speed)
	always @(posedge clk_sys) begin
		if (spi_in.sclk_fall | sdio_in.clk_fall)
			fall_cnt <= fall_cnt + 1;
		if (spi_in.sclk_rise | sdio_in.clk_rise) begin
			rise_cnt <= rise_cnt + 1;
			data_sh  <= {data_sh[6:0], spi_in.sclk_rise ? spi_in.mosi : sdio_in.cmd};
			miso_sh  <= {miso_sh[6:0], pins_i.dat0};
		end
	end

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic rst(input logic s);
		@(posedge clk_sys);
		arst_n <= 1'b0;
		strap  <= s;
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (6) @(posedge clk_sys);
		#1;
	endtask : rst

	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out

	initial begin
		#100us;
		bad_count++;
		close_out;
	end

	initial begin
		repeat (3) @(posedge clk_sys);
		#1;
		chk("oe_in_reset", pins_oe, 0);
		chk("valid_in_reset", mode_valid, 0);
		@(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		chk("select_after_reset", spi_in.select, 0);
		repeat (3) @(posedge clk_sys);
		#1;
		chk("mode_spi", port_mode, HPSEL_SPI);
		chk("mode_valid", mode_valid, 1);
		$display("test reset_spi done");
		foreach (rows[r]) begin
			@(posedge clk_sys);
			{ps, mir, wake_req, slp, irq, goe, gout} <= rows[r][10:4];
			repeat (9) @(posedge clk_sys);
			#1;
			chk("sleep_grant", sleep_grant, rows[r][3]);
			chk("mirror_oe", moe, rows[r][1]);
			chk("wake_oe", woe, rows[r][0]);
			if (rows[r][1])
				chk("mirror_out", mo, rows[r][2]);
			if (rows[r][0])
				chk("wake_out", wo, gout);
			chk("dat1_irq", {pins_oe.dat1, pins_o.dat1}, {1'b1, irq});
			chk("wake_in", hwi, ps & wake_req);
			chk("wake_gpio_in", wgi, !ps & wake_req);
			chk("mirror_in", mgi, !mir & (goe ? gout : wake_req));
		end
		$display("test sideband rows done");
		@(posedge clk_sys);
		spi_out  <= '{miso: 1'b0, miso_oe: 1'b1};
		rise_cnt <= 0;
		fall_cnt <= 0;
		host_u.frame(8'ha5, 1'b1);
		chk("spi_edges", rise_cnt, 8);
		chk("spi_falls", fall_cnt, 8);
		chk("spi_mosi", data_sh, 8'ha5);
		chk("spi_miso", miso_sh, 8'h00);
		chk("miso_oe_idle", pins_oe.dat0, 0);
		chk("select_idle", spi_in.select, 0);
		rise_cnt <= 0;
		fall_cnt <= 0;
		host_u.frame(8'h3c, 1'b0);
		chk("edges_unselected", rise_cnt + fall_cnt, 0);
		@(posedge clk_sys);
		strap <= 1'b1;
		repeat (8) @(posedge clk_sys);
		#1;
		chk("mode_held", port_mode, HPSEL_SPI);
		$display("test spi frames done");
		rst(1'b1);
		chk("mode_sdio", port_mode, HPSEL_SDIO);
		@(posedge clk_sys);
		sdio_out <= '{cmd: 1'b1, cmd_oe: 1'b1, dat: 4'b1010, dat_oe: 4'b1011};
		repeat (3) @(posedge clk_sys);
		#1;
		chk("sdio_oe", pins_oe, 4'b1111);
		chk("sdio_out", pins_o, 4'b1011);
		chk("dat2_oe", d2_oe, 0);
		chk("dat2_in", sdio_in.dat[2], 1);
		@(posedge clk_sys);
		sdio_out.cmd_oe <= 1'b0;
		rise_cnt        <= 0;
		fall_cnt        <= 0;
		host_u.frame(8'h96, 1'b1);
		chk("sdio_edges", rise_cnt, 8);
		chk("sdio_falls", fall_cnt, 8);
		chk("sdio_cmd", data_sh, 8'h96);
		chk("sdio_dat0", miso_sh, 8'h00);
		$display("test sdio done");
		@(posedge clk_sys);
		cen      <= 1'b0;
		sdio_out <= '0;
		repeat (4) @(posedge clk_sys);
		#1;
		chk("frozen_oe", pins_oe, 4'b0111);
		@(posedge clk_sys);
		cen <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		chk("thawed_oe", pins_oe, 4'b0000);
		$display("test clock enable done");
		close_out;
	end
endmodule : tb
